// file: ssf_top.sv
// Serial-port status flags with AHB-Lite register slave and slave shifter
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RULE1] Transmit empty set when holding empty, write clears
// [RULE2] Transmit empty reads zero if full or disabled
// [RULE3] Sticky underrun at bit 6, write one clears
// [RULE4] Sticky collision at bit 5 on mode fault
// [RULE5] Slave abort when select drops mid character
// [RULE6] Slave abort also on clock monitor timeout
// [RULE7] Sticky receive overrun at bit 3, write clears
// [RULE8] Bit 2 high while receive data unread
// [RULE9] Bit 1 high while transfer in progress
// [RULE10] Bit 0 shows live select pin level
// [RULE11] Status returns to reset while disabled
// [RULE12] Length code zero means eight bits
// [RULE13] Overrun when character lands on unread data
// [RULE14] Underrun when character starts with holding empty
module ssf_top import ssf_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	output logic irq
);
	// ----------------------------------------------------------------
	// Engine
	// ----------------------------------------------------------------
	ssf_link_if lk();

	ssf_link u_link (
		.hclk(hclk),
		.hresetn(hresetn),
		.sck(sck),
		.ss_n(ss_n),
		.mosi(mosi),
		.lk(lk)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic take, rd_take, rx_read, wr_do, st_wr, tx_wr, en;
	logic ap_wr_r, ap_wr_nxt;
	logic [11:0] ap_addr_r, ap_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [7:0] ctrl_r, ctrl_nxt, mask_r, mask_nxt, stat;

	// Only whole-word accesses are expected; hsize is accepted but not used
	always_comb begin
		take = hsel & htrans[1] & hready;
		rd_take = take & ~hwrite;
		rx_read = rd_take & (haddr[11:0] == ADDR_RXD);
		ap_wr_nxt = take & hwrite;
		ap_addr_nxt = take ? haddr[11:0] : ap_addr_r;
		wr_do = ap_wr_r;
		st_wr = wr_do & (ap_addr_r == ADDR_STATUS);
		tx_wr = wr_do & (ap_addr_r == ADDR_TXD) & en;
		ctrl_nxt = (wr_do && ap_addr_r == ADDR_CTRL) ? hwdata[7:0] : ctrl_r;
		mask_nxt = (wr_do && ap_addr_r == ADDR_MASK) ? (hwdata[7:0] & STICKY_MASK) : mask_r;
	end

	// ----------------------------------------------------------------
	// Data holding and sticky flags
	// ----------------------------------------------------------------
	logic [7:0] txh_r, txh_nxt, rxd_r, rxd_nxt, stk_r, stk_nxt, set_v, clr_v;
	logic txf_r, txf_nxt, rxf_r, rxf_nxt, ovr, irq_r, irq_nxt;

	assign en = ctrl_r[CT_EN];

	always_comb begin
		ovr = lk.char_done & rxf_r & ~rx_read; // RULE13
		set_v = 8'h00;
		set_v[ST_TX_UNDERRUN_FLAG] = lk.underrun; // RULE3
		set_v[ST_COL] = lk.collision; // RULE4
		set_v[ST_ABT] = lk.abort; // RULE5 RULE6
		set_v[ST_RX_OVERRUN_FLAG] = ovr; // RULE7
		clr_v = st_wr ? (hwdata[7:0] & STICKY_MASK) : 8'h00;
		// Set beats clear so an event in the clearing cycle is kept
		stk_nxt = en ? (((stk_r & ~clr_v) | set_v) & STICKY_MASK) : 8'h00; // RULE11
		txh_nxt = tx_wr ? hwdata[7:0] : txh_r;
		txf_nxt = en & (tx_wr | (txf_r & ~lk.load_tx)); // RULE1
		rxd_nxt = lk.char_done ? lk.rx_byte : rxd_r;
		rxf_nxt = en & (lk.char_done | (rxf_r & ~rx_read)); // RULE8
		irq_nxt = |(stk_r & mask_r);
	end

	// ----------------------------------------------------------------
	// Status view and read data
	// ----------------------------------------------------------------
	always_comb begin
		if (en) begin
			stat = {~txf_r, stk_r[ST_TX_UNDERRUN_FLAG:ST_RX_OVERRUN_FLAG], rxf_r, lk.active, lk.ss_level}; // RULE1 RULE8 RULE9 RULE10
		end else begin
			stat = STATUS_OFF; // RULE2 RULE11
		end
		hrdata_nxt = hrdata_r;
		if (rd_take) begin
			case (haddr[11:0])
				ADDR_STATUS: hrdata_nxt = {24'h0, stat};
				ADDR_CTRL: hrdata_nxt = {24'h0, ctrl_r};
				ADDR_MASK: hrdata_nxt = {24'h0, mask_r};
				ADDR_TXD: hrdata_nxt = {24'h0, txh_r};
				ADDR_RXD: hrdata_nxt = {24'h0, rxd_r};
				default: hrdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r <= 1'b0;
			ap_addr_r <= 12'h000;
			hrdata_r <= 32'h0;
			ctrl_r <= CTRL_RST;
			mask_r <= MASK_RST;
			txh_r <= BYTE_RST;
			txf_r <= 1'b0;
			rxd_r <= BYTE_RST;
			rxf_r <= 1'b0;
			stk_r <= 8'h00;
			irq_r <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ap_wr_r <= ap_wr_nxt;
			ap_addr_r <= ap_addr_nxt;
			hrdata_r <= hrdata_nxt;
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			txh_r <= txh_nxt;
			txf_r <= txf_nxt;
			rxd_r <= rxd_nxt;
			rxf_r <= rxf_nxt;
			stk_r <= stk_nxt;
			irq_r <= irq_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Engine controls and outputs
	// ----------------------------------------------------------------
	assign lk.enable = en;
	assign lk.master_enable = ctrl_r[CT_MEN];
	assign lk.baud_gen_control = ctrl_r[CT_BGC];
	assign lk.char_length = ctrl_r[CT_LEN+2:CT_LEN];
	assign lk.tx_byte = txh_r;
	assign lk.tx_full = txf_r;
	assign hrdata = hrdata_r;
	assign miso = lk.miso;
	assign miso_oe = lk.miso_oe;
	assign irq = irq_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	tx_write_a: assert property (tx_wr |=> !stat[ST_TX_BUFFER_EMPTY] && txh_r == $past(hwdata[7:0])) // RULE1
		else $error("transmit write did not clear empty flag");
	tx_empty_a: assert property (en && !txf_r && $past(en) |-> stat[ST_TX_BUFFER_EMPTY]) // RULE1
		else $error("empty holding not shown as empty");
	tx_off_a: assert property (!en |-> !stat[ST_TX_BUFFER_EMPTY]) // RULE2
		else $error("empty flag shown while disabled");
	undr_set_a: assert property (en && lk.underrun |=> stk_r[ST_TX_UNDERRUN_FLAG]) // RULE3 RULE14
		else $error("underrun not recorded");
	undr_keep_a: assert property (st_wr && en && !hwdata[ST_TX_UNDERRUN_FLAG] && stk_r[ST_TX_UNDERRUN_FLAG] |=> stk_r[ST_TX_UNDERRUN_FLAG]) // RULE3
		else $error("writing zero cleared underrun");
	undr_clr_a: assert property (st_wr && hwdata[ST_TX_UNDERRUN_FLAG] && !lk.underrun |=> !stk_r[ST_TX_UNDERRUN_FLAG]) // RULE3
		else $error("write one did not clear underrun");
	col_set_a: assert property (en && lk.collision |=> stk_r[ST_COL] ##1 (stk_r[ST_COL] || $past(st_wr))) // RULE4
		else $error("collision not recorded");
	abort_set_a: assert property (en && lk.abort |=> stk_r[ST_ABT]) // RULE5 RULE6
		else $error("abort not recorded");
	ovr_set_a: assert property (en && lk.char_done && rxf_r && !rx_read |=> stk_r[ST_RX_OVERRUN_FLAG] && rxf_r) // RULE7 RULE13
		else $error("overrun not recorded");
	rx_full_a: assert property (en && lk.char_done |=> stat[ST_RX_BUFFER_FULL] && rxd_r == $past(lk.rx_byte)) // RULE8
		else $error("received character not flagged");
	active_a: assert property (en |-> stat[ST_TRANSFER_ACTIVE] == lk.active) // RULE9
		else $error("transfer status mismatch");
	ss_level_a: assert property (en && $stable(ss_n)[*4] |-> stat[ST_SELECT_PIN_LEVEL] == ss_n) // RULE10
		else $error("select level not shown");
	off_reset_a: assert property (!en |-> stat == STATUS_OFF ##1 (stk_r == 8'h00 && !rxf_r && !txf_r)) // RULE11
		else $error("status not reset while disabled");

	underrun_c: cover property (lk.underrun ##1 stk_r[ST_TX_UNDERRUN_FLAG]);
	overrun_c: cover property (ovr ##1 irq_nxt);
	abort_c: cover property (lk.active ##[1:200] lk.abort);
	irq_c: cover property ($rose(irq));
endmodule : ssf_top
`default_nettype wire

// file: ssf_pkg.sv
// Constants, register map and helpers of the serial-port status flag block
package ssf_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses, low 12 address bits decoded)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_STATUS = 12'hf64;
	localparam logic [11:0] ADDR_CTRL = 12'hf68;
	localparam logic [11:0] ADDR_MASK = 12'hf6c;
	localparam logic [11:0] ADDR_TXD = 12'hf70;
	localparam logic [11:0] ADDR_RXD = 12'hf74;
	// ----------------------------------------------------------------
	// Status field positions and values
	// ----------------------------------------------------------------
	localparam int ST_TX_BUFFER_EMPTY = 7;
	localparam int ST_TX_UNDERRUN_FLAG = 6;
	localparam int ST_COL = 5;
	localparam int ST_ABT = 4;
	localparam int ST_RX_OVERRUN_FLAG = 3;
	localparam int ST_RX_BUFFER_FULL = 2;
	localparam int ST_TRANSFER_ACTIVE = 1;
	localparam int ST_SELECT_PIN_LEVEL = 0;
	localparam logic [7:0] STICKY_MASK = 8'h78;
	localparam logic [7:0] STATUS_OFF = 8'h01;
	// ----------------------------------------------------------------
	// Control field positions and reset values
	// ----------------------------------------------------------------
	localparam int CT_EN = 0;
	localparam int CT_MEN = 1;
	localparam int CT_BGC = 2;
	localparam int CT_LEN = 3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] TX_IDLE = 8'hff;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 20;
	localparam int SCK_TO_NS = 10000;
	localparam logic [7:0] SCK_TO_CYC = 8'((SCK_TO_NS * CLK_MHZ) / 1000);
	localparam logic [3:0] BITS_FULL = 4'h8;

	function automatic logic [3:0] ssf_char_bits(input logic [2:0] len);
		return (len == 3'h0) ? BITS_FULL : {1'b0, len};
	endfunction : ssf_char_bits
endpackage : ssf_pkg

// file: ssf_link_if.sv
// Signals between the register side and the serial engine
`timescale 1ns/1ns
`default_nettype none
interface ssf_link_if;
	logic enable;
	logic master_enable;
	logic baud_gen_control;
	logic [2:0] char_length;
	logic [7:0] tx_byte;
	logic tx_full;
	logic load_tx;
	logic char_done;
	logic [7:0] rx_byte;
	logic underrun;
	logic abort;
	logic collision;
	logic active;
	logic ss_level;
	logic miso;
	logic miso_oe;
	modport engine(input enable, master_enable, baud_gen_control, char_length, tx_byte, tx_full,
		output load_tx, char_done, rx_byte, underrun, abort, collision, active, ss_level, miso, miso_oe);
	modport regs(output enable, master_enable, baud_gen_control, char_length, tx_byte, tx_full,
		input load_tx, char_done, rx_byte, underrun, abort, collision, active, ss_level, miso, miso_oe);
endinterface : ssf_link_if
`default_nettype wire

// file: ssf_link.sv
// Serial engine: pin synchronisers, slave shifter and link events
`timescale 1ns/1ns
`default_nettype none
module ssf_link import ssf_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	ssf_link_if.engine lk
);
	typedef enum logic [1:0] {LK_IDLE, LK_WAIT, LK_SHIFT} ssf_lk_state_t;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic sck_m_r, sck_s_r, sck_d_r, ss_m_r, ss_s_r, ss_d_r, mosi_m_r, mosi_s_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{sck_m_r, sck_s_r, sck_d_r} <= 3'h0;
			{ss_m_r, ss_s_r, ss_d_r} <= 3'h7;
			{mosi_m_r, mosi_s_r} <= 2'h0;
		end else begin
			{sck_m_r, sck_s_r, sck_d_r} <= {sck, sck_m_r, sck_s_r};
			{ss_m_r, ss_s_r, ss_d_r} <= {ss_n, ss_m_r, ss_s_r};
			{mosi_m_r, mosi_s_r} <= {mosi, mosi_m_r};
		end
	end

	// ----------------------------------------------------------------
	// Shifter
	// ----------------------------------------------------------------
	ssf_lk_state_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt, bits;
	logic [7:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt, to_r, to_nxt;
	logic loaded_r, loaded_nxt, miso_r, miso_nxt, oe_r, oe_nxt;
	logic rise, fall, sel, preload, monitor;

	always_comb begin
		rise = sck_s_r & ~sck_d_r;
		fall = ~sck_s_r & sck_d_r;
		sel = lk.enable & ~lk.master_enable & ~ss_s_r;
		monitor = ~lk.master_enable & lk.baud_gen_control;
		bits = ssf_char_bits(lk.char_length); // RULE12
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rx_sh_nxt = rx_sh_r;
		tx_sh_nxt = tx_sh_r;
		loaded_nxt = loaded_r;
		miso_nxt = miso_r;
		to_nxt = 8'h00;
		preload = 1'b0;
		lk.load_tx = 1'b0;
		lk.char_done = 1'b0;
		lk.underrun = 1'b0;
		lk.abort = 1'b0;
		lk.collision = lk.enable & lk.master_enable & ~ss_s_r & ss_d_r; // RULE4
		lk.rx_byte = {rx_sh_r[6:0], mosi_s_r};
		case (st_r)
			LK_IDLE: begin
				if (sel) begin
					st_nxt = LK_WAIT;
					preload = 1'b1;
				end
			end
			LK_WAIT, LK_SHIFT: begin
				if (!sel) begin
					st_nxt = LK_IDLE;
					lk.abort = (st_r == LK_SHIFT) & lk.enable; // RULE5
				end else if (st_r == LK_SHIFT && monitor && to_r == SCK_TO_CYC - 8'h01) begin
					lk.abort = 1'b1; // RULE6
					st_nxt = LK_WAIT;
				end else if (rise) begin
					lk.underrun = (st_r == LK_WAIT) & ~loaded_r; // RULE14
					rx_sh_nxt = lk.rx_byte;
					cnt_nxt = ((st_r == LK_WAIT) ? 4'h0 : cnt_r) + 4'h1;
					if (cnt_nxt == bits) begin
						lk.char_done = 1'b1; // RULE12
						st_nxt = LK_WAIT;
						preload = 1'b1;
					end else begin
						st_nxt = LK_SHIFT;
					end
				end else if (fall && st_r == LK_SHIFT) begin
					tx_sh_nxt = {tx_sh_r[6:0], 1'b1};
					miso_nxt = tx_sh_r[6];
				end else if (st_r == LK_SHIFT && monitor) begin
					to_nxt = to_r + 8'h01;
				end
			end
			default: st_nxt = LK_IDLE;
		endcase
		// Next character is fetched early so its first bit is on the pin before the first edge
		if (preload) begin
			lk.load_tx = lk.tx_full;
			loaded_nxt = lk.tx_full;
			tx_sh_nxt = lk.tx_full ? lk.tx_byte : TX_IDLE;
			miso_nxt = tx_sh_nxt[7];
		end
		oe_nxt = sel;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= LK_IDLE;
			cnt_r <= 4'h0;
			rx_sh_r <= BYTE_RST;
			tx_sh_r <= TX_IDLE;
			to_r <= 8'h00;
			loaded_r <= 1'b0;
			miso_r <= 1'b1;
			oe_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			rx_sh_r <= rx_sh_nxt;
			tx_sh_r <= tx_sh_nxt;
			to_r <= to_nxt;
			loaded_r <= loaded_nxt;
			miso_r <= miso_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign lk.active = (st_r == LK_SHIFT); // RULE9
	assign lk.ss_level = ss_s_r; // RULE10
	assign lk.miso = miso_r;
	assign lk.miso_oe = oe_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	char_len_a: assert property (lk.char_done |-> cnt_nxt == ssf_char_bits(lk.char_length)) // RULE12
		else $error("character ended at wrong bit count");
	ss_abort_a: assert property (st_r == LK_SHIFT && lk.enable && ss_s_r |-> lk.abort) // RULE5
		else $error("select release mid character not aborted");
endmodule : ssf_link
`default_nettype wire

// file: ssf_spi_master.sv
// SPI master model driving the slave link of the status block
`timescale 1ns/1ns
`default_nettype none
module ssf_spi_master (
	output var logic sck,
	output var logic ss_n,
	output var logic mosi,
	input wire logic miso
);
	logic [7:0] rx;
	initial begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b1;
		rx = 8'h00;
	end
	// Odd offset keeps the ss_n edges off the hclk edges
	task automatic sel(input logic on);
		#17;
		ss_n = ~on;
		if (!on) begin
			mosi = ~mosi;
		end
		#400;
	endtask : sel
	// Mode 0, MSB first; long low phase gives the slow miso time to settle
	task automatic shift(input int n, input logic [7:0] d);
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			#250;
			sck = 1'b1;
			rx = {rx[6:0], miso};
			#150;
			sck = 1'b0;
		end
	endtask : shift
endmodule : ssf_spi_master
`default_nettype wire

// file: test_spi_status_flags.sv
// Self-checking bench of the serial-port status flag block
`timescale 1ns/1ns
`default_nettype none
module test_spi_status_flags import ssf_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic sck, ss_n, mosi, miso, miso_oe;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] mk;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	int n;
	typedef struct {logic [2:0] len; logic [7:0] tx; logic [7:0] dat;} ssf_row_t;
	ssf_row_t rows [4] = '{'{3'h0, 8'ha5, 8'h3c}, '{3'h1, 8'h00, 8'h01}, '{3'h4, 8'h00, 8'h0a},
		'{3'h7, 8'h00, 8'h55}};
	// Undriven miso toggles so a stale level never passes
	wire logic miso_pin = miso_oe ? miso : ~sck;
	ssf_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .irq(irq));
	ssf_spi_master p (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_pin));
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
		bus(1'b0, a, 32'h0);
		chk(rd & {24'h0, m}, {24'h0, e & m}, s);
		chk({30'h0, hresp, hreadyout}, 32'h1, "okay response");
	endtask : rchk
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(ADDR_STATUS, 8'hff, STATUS_OFF, "disabled");
		rchk(12'hf80, 8'hff, 8'h00, "unmapped");
		bus(1'b1, ADDR_CTRL, 32'h1);
		rchk(ADDR_STATUS, 8'hff, 8'h81, "idle");
		bus(1'b1, ADDR_TXD, 32'h5a);
		rchk(ADDR_STATUS, 8'h80, 8'h00, "tx full");
		foreach (rows[i]) begin
			n = (rows[i].len == 3'h0) ? 8 : int'(rows[i].len);
			mk = 8'((1 << n) - 1);
			bus(1'b1, ADDR_CTRL, {26'h0, rows[i].len, 3'h1});
			bus(1'b1, ADDR_TXD, {24'h0, rows[i].tx});
			p.sel(1'b1);
			rchk(ADDR_STATUS, 8'h81, 8'h80, "selected");
			chk({31'h0, miso_oe}, 32'h1, "miso driven");
			p.shift(n, rows[i].dat);
			p.sel(1'b0);
			rchk(ADDR_STATUS, 8'hff, 8'h85, "char done");
			rchk(ADDR_RXD, mk, rows[i].dat, "rx data");
			if (n == 8)
				chk({24'h0, p.rx}, {24'h0, rows[i].tx}, "miso byte");
			rchk(ADDR_STATUS, 8'h04, 8'h00, "rx read");
			$display("test row %0d done", i);
		end
		bus(1'b1, ADDR_CTRL, 32'h1);
		bus(1'b1, ADDR_TXD, 32'hc3);
		p.sel(1'b1);
		p.shift(4, 8'h0);
		rchk(ADDR_STATUS, 8'h02, 8'h02, "mid char");
		p.shift(4, 8'h0);
		p.shift(8, 8'h0);
		p.sel(1'b0);
		rchk(ADDR_STATUS, 8'h4a, 8'h48, "errors");
		chk({24'h0, p.rx}, 32'hff, "underrun ones");
		bus(1'b1, ADDR_MASK, 32'h08);
		bus(1'b1, ADDR_STATUS, 32'h0);
		rchk(ADDR_STATUS, 8'h48, 8'h48, "write zero");
		chk({31'h0, irq}, 32'h1, "irq raised");
		bus(1'b1, ADDR_MASK, 32'h0);
		rchk(ADDR_MASK, 8'h78, 8'h00, "mask off");
		chk({31'h0, irq}, 32'h0, "irq masked");
		bus(1'b1, ADDR_MASK, 32'h08);
		bus(1'b1, ADDR_STATUS, 32'h48);
		rchk(ADDR_STATUS, 8'h48, 8'h00, "cleared");
		chk({31'h0, irq}, 32'h0, "irq cleared");
		$display("test errors done");
		bus(1'b1, ADDR_TXD, 32'h11);
		p.sel(1'b1);
		p.shift(3, 8'h0);
		p.sel(1'b0);
		rchk(ADDR_STATUS, 8'h10, 8'h10, "select abort");
		bus(1'b1, ADDR_STATUS, 32'h10);
		bus(1'b1, ADDR_CTRL, 32'h05);
		bus(1'b1, ADDR_TXD, 32'h22);
		p.sel(1'b1);
		p.shift(3, 8'h0);
		#12000;
		rchk(ADDR_STATUS, 8'h10, 8'h10, "sck timeout");
		p.sel(1'b0);
		$display("test abort done");
		bus(1'b1, ADDR_CTRL, 32'h03);
		p.sel(1'b1);
		rchk(ADDR_STATUS, 8'h21, 8'h20, "collision");
		p.sel(1'b0);
		bus(1'b1, ADDR_CTRL, 32'h0);
		rchk(ADDR_STATUS, 8'hff, STATUS_OFF, "off again");
		$display("test collision done");
		report_and_stop();
	end
endmodule : test_spi_status_flags
`default_nettype wire
